// ==== usp_pkg.sv ====
// Purpose: Shared constants and types for the four-mode serial port.
// Assumes: 20 MHz mclk; AHB-Lite register access with 32-bit words.
// Notes:   Register offsets are byte addresses within a 16-byte window.
`default_nettype none
package usp_pkg;
  localparam int DW = 32;
  localparam int AW = 32;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Register byte offsets
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_BUF  = 4'h4;
  localparam logic [3:0] ADR_PWR  = 4'h8;
  localparam logic [3:0] ADR_TMR  = 4'hc;
  // serial_control_register fields
  localparam int B_RXDONE = 0;
  localparam int B_TXDONE = 1;
  localparam int B_RX9    = 2;
  localparam int B_TX9    = 3;
  localparam int B_REN    = 4;
  localparam int B_FILT   = 5;
  localparam int MODE_LO  = 6;
  localparam int MODE_HI  = 7;
  localparam int B_IEN    = 8;
  // power_control_register and timer configuration fields
  localparam int B_DBL    = 7;
  localparam int T1R_HI   = 7;
  localparam int B_T1SEL  = 8;
  localparam int B_TXT2   = 9;
  localparam int B_RXT2   = 10;
  localparam int T2R_LO   = 16;
  localparam int T2R_HI   = 31;
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [7:0]  RST_T1R  = 8'h00;
  localparam logic [15:0] RST_T2R  = 16'h0000;
  // Timing counts (terminal values; M0_HALF and OS_MID are mid-point values)
  localparam logic [3:0]  M0_DIV_M1  = 4'hb;
  localparam logic [3:0]  M0_HALF    = 4'h6;
  localparam logic [3:0]  M0_LAST    = 4'h7;
  localparam logic [3:0]  OS_LAST    = 4'hf;
  localparam logic [3:0]  OS_MID     = 4'h7;
  localparam logic [1:0]  M2_SLOW_M1 = 2'h3;
  localparam logic [1:0]  M2_FAST_M1 = 2'h1;
  localparam logic [3:0]  T1_PRE_M1  = 4'hb;
  localparam logic [7:0]  T1_TOP     = 8'hff;
  localparam logic [15:0] T2_TOP     = 16'hffff;
  localparam logic [3:0]  STOP8_IDX  = 4'h9;
  localparam logic [3:0]  STOP9_IDX  = 4'ha;
  localparam logic [3:0]  RX8_LAST   = 4'h7;
  localparam logic [3:0]  RX9_LAST   = 4'h8;
  typedef enum logic [1:0] {MODE_SYNC, MODE_ASYNC8, MODE_FIX9, MODE_VAR9} usp_mode_type;
  typedef enum logic [2:0] {TX_IDLE, TX_ASYNC, TX_SYNC_OUT, TX_SYNC_IN, TX_SYNC_END}
    usp_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} usp_rx_state_type;
endpackage : usp_pkg
`default_nettype wire

// ==== usp_tick_if.sv ====
// Purpose: Timer configuration and overflow ticks between core and timers.
// Assumes: Single mclk domain.
// Notes:   Ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface usp_tick_if;
  logic [7:0]  t1_reload;
  logic        t1_fast;
  logic [15:0] t2_reload;
  logic        t1_ovf;
  logic        t2_ovf;
  modport gen (input t1_reload, input t1_fast, input t2_reload,
               output t1_ovf, output t2_ovf);
  modport core (output t1_reload, output t1_fast, output t2_reload,
                input t1_ovf, input t2_ovf);
endinterface : usp_tick_if
`default_nettype wire

// ==== usp_baud_gen.sv ====
// Purpose: Timer 1 (8-bit auto-reload) and Timer 2 (16-bit reload) tick sources.
// Assumes: Timer 2 counts at mclk/2; Timer 1 at mclk or mclk/12.
// Notes:   Overflow ticks are registered one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module usp_baud_gen (
  input wire logic mclk,
  input wire logic sys_rst,
  usp_tick_if.gen  tk
);
  import usp_pkg::*;
  logic [3:0]  pre_r;
  logic        t2_ph_r;
  logic [7:0]  t1_cnt_r;
  logic [15:0] t2_cnt_r;
  logic        t1_ovf_r;
  logic        t2_ovf_r;
  logic [7:0]  t1_rl_r;
  logic [15:0] t2_rl_r;
  wire         pre_end = (pre_r == T1_PRE_M1);
  wire         t1_en   = tk.t1_fast | pre_end;
  wire         t1_wrap = t1_en & (t1_cnt_r == T1_TOP);
  wire         t2_wrap = t2_ph_r & (t2_cnt_r == T2_TOP);
  // A new reload value restarts the count, so the first overflow is not a full wrap away
  wire         t1_new  = (tk.t1_reload != t1_rl_r);
  wire         t2_new  = (tk.t2_reload != t2_rl_r);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r   <= 4'h0;
      t2_ph_r <= 1'b0;
    end else begin
      pre_r   <= pre_end ? 4'h0 : pre_r + 4'h1;
      t2_ph_r <= ~t2_ph_r;
    end
  end

  // Auto-reload: the count restarts at the reload value, so rate = clk/(256-reload)
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      t1_cnt_r <= RST_T1R;
      t1_ovf_r <= 1'b0;
      t1_rl_r  <= RST_T1R;
    end else begin
      t1_ovf_r <= t1_wrap;
      t1_rl_r  <= tk.t1_reload;
      if (t1_wrap | t1_new) t1_cnt_r <= tk.t1_reload;
      else if (t1_en) t1_cnt_r <= t1_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      t2_cnt_r <= RST_T2R;
      t2_ovf_r <= 1'b0;
      t2_rl_r  <= RST_T2R;
    end else begin
      t2_ovf_r <= t2_wrap;
      t2_rl_r  <= tk.t2_reload;
      if (t2_wrap | t2_new) t2_cnt_r <= tk.t2_reload;
      else if (t2_ph_r) t2_cnt_r <= t2_cnt_r + 16'h0001;
    end
  end

  assign tk.t1_ovf = t1_ovf_r;
  assign tk.t2_ovf = t2_ovf_r;
endmodule : usp_baud_gen
`default_nettype wire

// ==== usp_top.sv ====
// Purpose: Four-mode serial port (sync shift mode, three async modes) on AHB-Lite.
// Assumes: One 20 MHz clock; single-word AHB transfers; receive pin is open-drain.
// Notes:   Writes take effect in the data phase; reads answer with zero waits.
`timescale 1ns/1ps
`default_nettype none
module usp_top (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  hsel,
  input  wire logic [usp_pkg::AW-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [usp_pkg::DW-1:0] hwdata,
  input  wire logic                  hready,
  output var  logic                  hreadyout,
  output var  logic [usp_pkg::DW-1:0] hrdata,
  output var  logic                  hresp,
  input  wire logic                  rxd_i,
  output var  logic                  rxd_o,
  output var  logic                  rxd_oe,
  output var  logic                  txd_o,
  output var  logic                  irq
);
  import usp_pkg::*;

  function automatic logic os_pick(usp_mode_type m, logic use_t2, logic t1os,
                                   logic t2os, logic m2os);
    logic r;
    r = use_t2 ? t2os : t1os;
    if (m == MODE_FIX9) r = m2os;
    return r;
  endfunction : os_pick

  usp_tick_if tick_if ();

  logic [7:0]       ctrl_r;
  logic [7:0]       ctrl_nxt;
  logic             ien_r;
  logic             dbl_r;
  logic [7:0]       t1_reload_r;
  logic             t1_fast_r;
  logic             tx_t2_r;
  logic             rx_t2_r;
  logic [15:0]      t2_reload_r;
  logic [7:0]       rx_buf_r;
  logic             wr_pend_r;
  logic [3:0]       wr_addr_r;
  logic [DW-1:0]    hrdata_r;
  logic             t1_ph_r;
  logic [1:0]       m2_cnt_r;
  logic             rx_s1_r;
  logic             rx_s2_r;
  logic             rx_s3_r;
  usp_tx_state_type tx_st_r;
  logic [10:0]      tx_sh_r;
  logic [3:0]       tx_os_r;
  logic [3:0]       tx_bit_r;
  logic [3:0]       m0_cnt_r;
  usp_rx_state_type rx_st_r;
  logic [8:0]       rx_sh_r;
  logic [3:0]       rx_os_r;
  logic [3:0]       rx_bit_r;
  logic             txd_r;
  logic             rxd_oe_r;
  logic             rxd_o_r;
  logic             irq_r;

  usp_baud_gen u_gen (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tk      (tick_if.gen)
  );

  assign tick_if.t1_reload = t1_reload_r;
  assign tick_if.t1_fast   = t1_fast_r;
  assign tick_if.t2_reload = t2_reload_r;

  // Bus decode
  wire          acc      = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire          in_range = (haddr[AW-1:4] == '0);
  wire          wr_ctrl  = wr_pend_r & (wr_addr_r == ADR_CTRL);
  wire          wr_buf   = wr_pend_r & (wr_addr_r == ADR_BUF);
  wire          wr_pwr   = wr_pend_r & (wr_addr_r == ADR_PWR);
  wire          wr_tmr   = wr_pend_r & (wr_addr_r == ADR_TMR);
  wire [DW-1:0] rd_ctrl  = {23'h000000, ien_r, ctrl_r};
  wire [DW-1:0] rd_buf   = {24'h000000, rx_buf_r};
  wire [DW-1:0] rd_pwr   = {24'h000000, dbl_r, 7'h00};
  wire [DW-1:0] rd_tmr   = {t2_reload_r, 5'h00, rx_t2_r, tx_t2_r, t1_fast_r, t1_reload_r};
  wire [DW-1:0] rd_word  = !in_range ? '0 :
                           (haddr[3:0] == ADR_CTRL) ? rd_ctrl :
                           (haddr[3:0] == ADR_BUF)  ? rd_buf  :
                           (haddr[3:0] == ADR_PWR)  ? rd_pwr  :
                           (haddr[3:0] == ADR_TMR)  ? rd_tmr  : '0;

  // Control fields
  wire usp_mode_type mode = usp_mode_type'(ctrl_r[MODE_HI:MODE_LO]);
  wire m0_sel  = (mode == MODE_SYNC);
  wire nine    = (mode == MODE_FIX9) | (mode == MODE_VAR9);
  wire ren     = ctrl_r[B_REN];
  wire filt    = ctrl_r[B_FILT];
  wire rx_done = ctrl_r[B_RXDONE];

  // Baud oversampling ticks, sixteen per bit
  wire m2_end = (m2_cnt_r == (dbl_r ? M2_FAST_M1 : M2_SLOW_M1));
  wire os_t1  = tick_if.t1_ovf & (dbl_r | t1_ph_r);
  wire os_t2  = tick_if.t2_ovf;
  wire tx_os  = os_pick(mode, tx_t2_r, os_t1, os_t2, m2_end);
  wire rx_os  = os_pick(mode, rx_t2_r, os_t1, os_t2, m2_end);

  // Transmit/sync engine decode
  wire [3:0] stop_idx  = nine ? STOP9_IDX : STOP8_IDX;
  wire       tx_idle   = (tx_st_r == TX_IDLE);
  wire       tx_bitend = tx_os & (tx_os_r == OS_LAST);
  wire       m0_end    = (m0_cnt_r == M0_DIV_M1);
  wire       m0_mid    = (m0_cnt_r == M0_HALF);
  wire       m0_last   = m0_end & (tx_bit_r == M0_LAST);
  wire       m0_rx_go  = tx_idle & m0_sel & ren & ~rx_done & ~wr_buf;
  wire       tx_set    = (tx_st_r == TX_ASYNC) & tx_bitend &
                         (tx_bit_r == stop_idx - 4'h1);
  wire       m0_tx_set = (tx_st_r == TX_SYNC_OUT) & m0_last;

  // Receive engine decode
  wire       rx_fall   = rx_s3_r & ~rx_s2_r;
  wire       rx_tkend  = rx_os & (rx_os_r == OS_LAST);
  wire [3:0] rx_last   = nine ? RX9_LAST : RX8_LAST;
  wire       rx9_val   = nine ? rx_sh_r[8] : rx_s2_r;
  wire [7:0] rx_data   = nine ? rx_sh_r[7:0] : rx_sh_r[8:1];
  wire       rx_load   = (rx_st_r == RX_STOP) & rx_tkend & ~rx_done &
                         (~filt | rx9_val);
  wire       m0_rx_ld  = (tx_st_r == TX_SYNC_END);

  // Bus slave: zero-wait, always OKAY
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 4'h0;
      hrdata_r  <= '0;
    end else begin
      wr_pend_r <= acc & hwrite & in_range;
      wr_addr_r <= haddr[3:0];
      if (acc & ~hwrite) hrdata_r <= rd_word;
    end
  end

  // Hardware sets win over a software clear in the same cycle
  always_comb begin
    ctrl_nxt = wr_ctrl ? hwdata[7:0] : ctrl_r;
    if (rx_load) ctrl_nxt[B_RX9] = rx9_val;
    if (tx_set | m0_tx_set) ctrl_nxt[B_TXDONE] = 1'b1;
    if (rx_load | m0_rx_ld) ctrl_nxt[B_RXDONE] = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r      <= RST_CTRL;
      ien_r       <= 1'b0;
      dbl_r       <= 1'b0;
      t1_reload_r <= RST_T1R;
      t1_fast_r   <= 1'b0;
      tx_t2_r     <= 1'b0;
      rx_t2_r     <= 1'b0;
      t2_reload_r <= RST_T2R;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_ctrl) ien_r <= hwdata[B_IEN];
      if (wr_pwr) dbl_r <= hwdata[B_DBL];
      if (wr_tmr) begin
        t1_reload_r <= hwdata[T1R_HI:0];
        t1_fast_r   <= hwdata[B_T1SEL];
        tx_t2_r     <= hwdata[B_TXT2];
        rx_t2_r     <= hwdata[B_RXT2];
        t2_reload_r <= hwdata[T2R_HI:T2R_LO];
      end
    end
  end

  // Received-byte holding register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) rx_buf_r <= 8'h00;
    else if (rx_load) rx_buf_r <= rx_data;
    else if (m0_rx_ld) rx_buf_r <= tx_sh_r[7:0];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      t1_ph_r  <= 1'b0;
      m2_cnt_r <= 2'h0;
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
    end else begin
      if (tick_if.t1_ovf) t1_ph_r <= ~t1_ph_r;
      m2_cnt_r <= m2_end ? 2'h0 : m2_cnt_r + 2'h1;
      rx_s1_r  <= rxd_i;
      rx_s2_r  <= rx_s1_r;
      rx_s3_r  <= rx_s2_r;
    end
  end

  // Transmitter and mode 0 shift engine
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_r  <= TX_IDLE;
      tx_sh_r  <= '1;
      tx_os_r  <= 4'h0;
      tx_bit_r <= 4'h0;
      m0_cnt_r <= 4'h0;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          tx_os_r  <= 4'h0;
          tx_bit_r <= 4'h0;
          m0_cnt_r <= 4'h0;
          if (wr_buf) begin
            // Frame: start, data LSB first, ninth or stop, stop
            tx_sh_r <= {1'b1, nine ? ctrl_r[B_TX9] : 1'b1, hwdata[7:0], 1'b0};
            if (m0_sel) tx_sh_r <= {3'h7, hwdata[7:0]};
            tx_st_r <= m0_sel ? TX_SYNC_OUT : TX_ASYNC;
          end else if (m0_rx_go) begin
            tx_st_r <= TX_SYNC_IN;
          end
        end
        TX_ASYNC: begin
          if (tx_os) tx_os_r <= tx_os_r + 4'h1;
          if (tx_bitend) begin
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == stop_idx) tx_st_r <= TX_IDLE;
          end
        end
        TX_SYNC_OUT, TX_SYNC_IN: begin
          m0_cnt_r <= m0_end ? 4'h0 : m0_cnt_r + 4'h1;
          if ((tx_st_r == TX_SYNC_IN) & m0_mid)
            tx_sh_r <= {3'h7, rx_s2_r, tx_sh_r[7:1]};
          if (m0_end) begin
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_st_r == TX_SYNC_OUT) tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          end
          if (m0_last) tx_st_r <= (tx_st_r == TX_SYNC_IN) ? TX_SYNC_END : TX_IDLE;
        end
        TX_SYNC_END: begin
          tx_st_r <= TX_IDLE;
        end
        default: begin
          tx_st_r <= TX_IDLE;
        end
      endcase
    end
  end

  // Asynchronous receiver
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_r  <= RX_IDLE;
      rx_sh_r  <= 9'h000;
      rx_os_r  <= 4'h0;
      rx_bit_r <= 4'h0;
    end else begin
      if (rx_os) rx_os_r <= rx_os_r + 4'h1;
      case (rx_st_r)
        RX_IDLE: begin
          rx_os_r  <= 4'h0;
          rx_bit_r <= 4'h0;
          if (~m0_sel & ren & rx_fall) rx_st_r <= RX_START;
        end
        RX_START: begin
          if (rx_os & (rx_os_r == OS_MID)) begin
            rx_os_r <= 4'h0;
            rx_st_r <= rx_s2_r ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_tkend) begin
            rx_sh_r  <= {rx_s2_r, rx_sh_r[8:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == rx_last) rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tkend) rx_st_r <= RX_IDLE;
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
      if (m0_sel) rx_st_r <= RX_IDLE;
    end
  end

  // Pin drivers; mode 0 clock low in first half of each bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_r    <= 1'b1;
      rxd_oe_r <= 1'b0;
      rxd_o_r  <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      case (tx_st_r)
        TX_ASYNC: txd_r <= tx_sh_r[0];
        TX_SYNC_OUT, TX_SYNC_IN: txd_r <= (m0_cnt_r >= M0_HALF);
        default: txd_r <= 1'b1;
      endcase
      rxd_oe_r <= (tx_st_r == TX_SYNC_OUT) & ~tx_sh_r[0];
      rxd_o_r  <= 1'b0;
      irq_r    <= ien_r & (ctrl_r[B_TXDONE] | ctrl_r[B_RXDONE]);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign txd_o     = txd_r;
  assign rxd_oe    = rxd_oe_r;
  assign rxd_o     = rxd_o_r;
  assign irq       = irq_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_tx_kick;
    tx_idle && wr_buf && !m0_sel;
  endsequence
  sequence s_m0_rx_done;
    (tx_st_r == TX_SYNC_IN) && m0_last ##1 (tx_st_r == TX_SYNC_END);
  endsequence

  a_tx_flag_hold: assert property (ctrl_r[B_TXDONE] && !wr_ctrl |=> ctrl_r[B_TXDONE])
    else $error("tx done flag cleared without a write");
  a_rx_flag_hold: assert property (ctrl_r[B_RXDONE] && !wr_ctrl |=> ctrl_r[B_RXDONE])
    else $error("rx done flag cleared without a write");
  a_irq_follows: assert property (ien_r && ctrl_r[B_TXDONE] |=> irq)
    else $error("interrupt missing with flag set");
  a_start_bit_low: assert property (s_tx_kick |=> ##1 !txd_o)
    else $error("start bit not low");
  a_m0_clk_high: assert property ((tx_st_r == TX_SYNC_OUT) && m0_mid |=> txd_o)
    else $error("mode 0 shift clock not high at mid bit");
  a_m0_tx_done: assert property (m0_tx_set |=> ctrl_r[B_TXDONE] && tx_idle)
    else $error("mode 0 transmit did not finish");
  a_m0_rx_wait: assert property (s_m0_rx_done |=> ctrl_r[B_RXDONE])
    else $error("mode 0 receive flag late");
  a_oe_only_sync: assert property (!m0_sel ##1 !m0_sel |-> !rxd_oe)
    else $error("receive pin driven outside mode 0");
  a_rx_reject: assert property ((rx_st_r == RX_STOP) && rx_tkend && rx_done
                                |=> $stable(rx_buf_r))
    else $error("holding register overwritten while flag set");
endmodule : usp_top
`default_nettype wire

// ==== usp_remote.sv ====
// Purpose: Remote serial device model facing the port's async link.
// Assumes: Bit time in mclk cycles, frame width and listening are set by the bench.
// Notes:   Line idles high; a stop bit of 0 is sent only when the bench asks for it.
`timescale 1ns/1ps
`default_nettype none
module usp_remote (
  input  wire logic mclk,
  input  wire logic txd,
  output var  logic drive
);
  int         bit_cyc = 32;
  bit         has9    = 1'b0;
  bit         listen  = 1'b0;
  int         frames  = 0;
  logic [8:0] got     = 9'h000;
  initial drive = 1'b1;
  // Start low, data LSB first, ninth bit if any, then stop
  task automatic send(input logic [7:0] d, input logic n, input logic stopv);
    logic [10:0] f;
    f = has9 ? {stopv, n, d, 1'b0} : {1'b1, stopv, d, 1'b0};
    for (int i = 0; i < (has9 ? 11 : 10); i++) begin
      drive <= f[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    drive <= 1'b1;
  endtask : send
  // Mode 0 peripheral: new bit on each falling shift clock, LSB first
  task automatic shift_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      drive <= d[i];
    end
    @(posedge txd);
    drive <= 1'b1;
  endtask : shift_out
  always begin
    @(negedge txd);
    if (listen) begin
      repeat (bit_cyc / 2) @(posedge mclk);
      for (int i = 0; i < (has9 ? 9 : 8); i++) begin
        repeat (bit_cyc) @(posedge mclk);
        got[i] = txd;
      end
      frames++;
    end
  end
endmodule : usp_remote
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the four-mode serial port.
// Assumes: AHB-Lite single word transfers; remote model on the async link.
// Notes:   Receive pin is open drain with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usp_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, rxd_o, rxd_oe, txd_o, irq, rem_drv, rxd_w;
  int          bad_count = 0, comparisons = 0;
  logic [7:0]  b, cap;
  logic        n9, prev;
  int          nb, falls, f0, per, fr;
  logic [31:0] cm [3] = '{32'h80, 32'h40, 32'hc0};
  logic [31:0] pw [3] = '{32'h80, 32'h80, 32'h0};
  logic [31:0] tm [3] = '{32'h0, 32'h1ff, 32'hffff0600};
  int          bc [3] = '{32, 16, 32};
  bit          h9 [3] = '{1'b1, 1'b0, 1'b1};
  assign rxd_w = rem_drv & ~(rxd_oe & ~rxd_o);
  usp_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd_i(rxd_w), .rxd_o(rxd_o),
    .rxd_oe(rxd_oe), .txd_o(txd_o), .irq(irq));
  usp_remote u_rem (.mclk(mclk), .txd(txd_o), .drive(rem_drv));
  initial forever #25 mclk = ~mclk;
  function automatic logic exp_ninth(input bit nine, input logic n);
    return nine ? n : 1'b1;
  endfunction : exp_ninth
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(61154));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b0, {28'h0, ADR_PWR}, 32'h0);
    chk("pwr reset", 32'h0, rd);
    bus(1'b1, 32'h10, 32'hffffffff);
    bus(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    b = 8'($urandom);
    bus(1'b1, {28'h0, ADR_BUF}, {24'h0, b});
    nb = 0;
    falls = 0;
    prev = 1'b1;
    for (int c = 0; c < 200; c++) begin
      @(posedge mclk);
      #1;
      if (!prev && txd_o && nb < 8) begin
        cap[nb] = rxd_w;
        nb++;
      end
      if (prev && !txd_o) begin
        if (falls == 0) f0 = c;
        if (falls == 1) per = c - f0;
        falls++;
      end
      prev = txd_o;
    end
    chk("mode0 data", {24'h0, b}, {24'h0, cap});
    chk("mode0 clocks", 32'd8, 32'(falls));
    chk("mode0 period", 32'd12, 32'(per));
    bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
    chk("mode0 tx done", 32'h1, {31'h0, rd[B_TXDONE]});
    chk("irq disabled", 32'h0, {31'h0, irq});
    b = 8'($urandom);
    bus(1'b1, {28'h0, ADR_CTRL}, 32'h10);
    u_rem.shift_out(b);
    repeat (12) @(posedge mclk);
    bus(1'b0, {28'h0, ADR_BUF}, 32'h0);
    chk("mode0 rx byte", {24'h0, b}, rd);
    bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
    chk("mode0 rx done", 32'h1, {31'h0, rd[B_RXDONE]});
    chk("rx pin level", 32'h0, {31'h0, rxd_o});
    chk("bus response", 32'h0, {31'h0, hresp});
    for (int k = 0; k < 3; k++) begin
      u_rem.bit_cyc = bc[k];
      u_rem.has9 = h9[k];
      u_rem.listen = 1'b1;
      bus(1'b1, {28'h0, ADR_PWR}, pw[k]);
      bus(1'b1, {28'h0, ADR_TMR}, tm[k]);
      n9 = 1'($urandom);
      b = 8'($urandom);
      bus(1'b1, {28'h0, ADR_CTRL}, cm[k] | 32'h110 | (32'(n9) << B_TX9));
      fr = u_rem.frames;
      bus(1'b1, {28'h0, ADR_BUF}, {24'h0, b});
      for (int c = 0; c < 1000 && u_rem.frames == fr; c++) @(posedge mclk);
      chk("tx byte", {24'h0, b}, {24'h0, u_rem.got[7:0]});
      if (h9[k]) chk("tx ninth", {31'h0, n9}, {31'h0, u_rem.got[8]});
      repeat (bc[k]) @(posedge mclk);
      bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
      chk("tx done", 32'h1, {31'h0, rd[B_TXDONE]});
      chk("irq tx", 32'h1, {31'h0, irq});
      b = 8'($urandom);
      n9 = 1'($urandom);
      u_rem.send(b, n9, 1'b1);
      bus(1'b0, {28'h0, ADR_BUF}, 32'h0);
      chk("rx byte", {24'h0, b}, rd);
      bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
      chk("rx ninth", {31'h0, exp_ninth(h9[k], n9)}, {31'h0, rd[B_RX9]});
      u_rem.send(~b, 1'b1, 1'b1);
      bus(1'b0, {28'h0, ADR_BUF}, 32'h0);
      chk("rx held", {24'h0, b}, rd);
      bus(1'b1, {28'h0, ADR_CTRL}, cm[k] | 32'h130);
      bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      u_rem.send(b ^ 8'h5a, 1'b0, h9[k]);
      bus(1'b0, {28'h0, ADR_CTRL}, 32'h0);
      chk("filter drop", 32'h0, {31'h0, rd[B_RXDONE]});
      u_rem.send(b ^ 8'h5a, 1'b1, 1'b1);
      bus(1'b0, {28'h0, ADR_BUF}, 32'h0);
      chk("filter pass", {24'h0, b ^ 8'h5a}, rd);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
